/* File: fscwp_pkg.sv */
// constants and types of the flash status and write-protect block
package fscwp_pkg;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_WEL_BIT   = 1;
  localparam int STAT_BP_LO_BIT = 2;
  localparam int STAT_TB_BIT    = 5;
  localparam int STAT_BP3_BIT   = 6;
  localparam int STAT_SRWD_BIT  = 7;

  localparam logic       RST_SRWD = 1'b0;
  localparam logic       RST_TB   = 1'b0;
  localparam logic [3:0] RST_BP   = 4'h0;
  localparam logic       RST_WEL  = 1'b0;

  localparam int          SECTOR_LSB   = 16;
  localparam int          SECTOR_W     = 12;
  localparam logic [12:0] SECTOR_COUNT = 13'h1000;
  localparam logic [3:0]  BP_ALL_FROM  = 4'hd;

  localparam int CLK_MHZ      = 100;
  localparam int WRSR_TIME_NS = 1000;
  localparam int WRSR_CYCLES  = (WRSR_TIME_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    CMD_WRITE_ENABLE,
    CMD_WRITE_DISABLE,
    CMD_READ_STATUS,
    CMD_WRITE_STATUS,
    CMD_PROGRAM,
    CMD_ERASE_SECTOR,
    CMD_ERASE_DIE
  } fscwp_cmd_type;

  typedef enum logic [1:0] {
    ARR_PROGRAM,
    ARR_ERASE_SECTOR,
    ARR_ERASE_DIE
  } fscwp_arr_op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STATUS_WRITE,
    ST_ARRAY_OP
  } fscwp_state_type;
endpackage

/* File: fscwp_prot_if.sv */
// protection query between the status logic and the region check
`timescale 1ns/1ps
`default_nettype none
interface fscwp_prot_if;
  logic [3:0]  bp;
  logic        tb;
  logic [11:0] sector;
  logic        hit;
  modport checker_side (input bp, input tb, input sector, output hit);
  modport user_side    (output bp, output tb, output sector, input hit);
endinterface
`default_nettype wire

/* File: fscwp_protect_check.sv */
// decides whether a sector lies in the block-protected region
`timescale 1ns/1ps
`default_nettype none
module fscwp_protect_check (
  fscwp_prot_if.checker_side prot
);
  import fscwp_pkg::*;

  logic [12:0] span;

  always_comb begin
    if (prot.bp == 4'h0) begin
      span = 13'h0000;
    end else if (prot.bp >= BP_ALL_FROM) begin
      span = SECTOR_COUNT;
    end else begin
      span = 13'h0001 << (prot.bp - 4'h1);
    end
    if (prot.tb) begin
      prot.hit = {1'b0, prot.sector} < span;
    end else begin
      prot.hit = {1'b0, prot.sector} >= (SECTOR_COUNT - span);
    end
  end
endmodule
`default_nettype wire

/* File: fscwp_status_protect.sv */
// status register, write-enable latch and write-protect control
`timescale 1ns/1ps
`default_nettype none
module fscwp_status_protect #(
  parameter int WRSR_CYC = fscwp_pkg::WRSR_CYCLES
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     cmd_valid_i,
  input  wire fscwp_pkg::fscwp_cmd_type cmd_code_i,
  input  wire logic [31:0]              cmd_addr_i,
  input  wire logic [7:0]               cmd_data_i,
  input  wire logic                     wp_n_i,
  input  wire logic                     quad_io_i,
  input  wire logic                     array_done_i,
  output logic [7:0]                    status_o,
  output logic                          flag_ready_o,
  output logic [7:0]                    rd_data_o,
  output logic                          rd_valid_o,
  output logic                          reject_o,
  output logic                          array_start_o,
  output fscwp_pkg::fscwp_arr_op_type   array_op_o,
  output logic [31:0]                   array_addr_o
);
  import fscwp_pkg::*;

  // the busy counter is 16 bits wide and must count at least once
  if (WRSR_CYC < 1 || WRSR_CYC > 65535) begin : g_bad_wrsr_cyc
    $error("status write cycle count out of range");
  end

  // sector index must sit inside the command address
  if (SECTOR_LSB + SECTOR_W > 32) begin : g_bad_sector_field
    $error("sector field lies outside the address");
  end

  // every register of the block lives in this one struct
  typedef struct packed {
    fscwp_state_type  state;
    logic             srwd;
    logic             tb;
    logic [3:0]       bp;
    logic             wel;
    logic             busy;
    logic             ready;
    logic [15:0]      cnt;
    logic [7:0]       pend;
    logic [1:0]       wp_sync;
    logic [7:0]       rd_data;
    logic             rd_valid;
    logic             reject;
    logic             start;
    fscwp_arr_op_type op;
    logic [31:0]      addr;
  } fscwp_regs_type;

  fscwp_regs_type s_q;
  fscwp_regs_type s_d;
  logic           hw_locked;

  // region check looks at the raw command address
  fscwp_prot_if prot ();
  assign prot.bp     = s_q.bp;
  assign prot.tb     = s_q.tb;
  assign prot.sector = cmd_addr_i[SECTOR_LSB +: SECTOR_W];

  fscwp_protect_check u_check (
    .prot (prot)
  );

  function automatic logic [7:0] status_byte(input fscwp_regs_type r);
    logic [7:0] b;
    b = 8'h00;
    b[STAT_SRWD_BIT]              = r.srwd;
    b[STAT_BP3_BIT]               = r.bp[3];
    b[STAT_TB_BIT]                = r.tb;
    b[STAT_BP_LO_BIT +: 3]        = r.bp[2:0];
    b[STAT_WEL_BIT]               = r.wel;
    b[STAT_BUSY_BIT]              = r.busy;
    return b;
  endfunction

  // status writes need the latch and an unlocked register
  function automatic logic status_write_refused(input fscwp_regs_type r,
                                                input logic           locked);
    return !r.wel || locked;
  endfunction

  // array commands need the latch and an unprotected target
  function automatic logic array_refused(input fscwp_cmd_type  c,
                                         input fscwp_regs_type r,
                                         input logic           hit);
    logic refuse;
    refuse = !r.wel;
    if (c == CMD_ERASE_DIE) begin
      refuse = refuse || (r.bp != 4'h0);
    end else begin
      refuse = refuse || hit;
    end
    return refuse;
  endfunction

  function automatic fscwp_arr_op_type array_op_of(input fscwp_cmd_type c);
    fscwp_arr_op_type o;
    case (c)
      CMD_PROGRAM:      o = ARR_PROGRAM;
      CMD_ERASE_SECTOR: o = ARR_ERASE_SECTOR;
      default:          o = ARR_ERASE_DIE;
    endcase
    return o;
  endfunction

  // new status bits take effect only when the write cycle ends
  function automatic fscwp_regs_type commit_status(input fscwp_regs_type r);
    fscwp_regs_type n;
    n       = r;
    n.srwd  = r.pend[STAT_SRWD_BIT];
    n.tb    = r.pend[STAT_TB_BIT];
    n.bp    = {r.pend[STAT_BP3_BIT], r.pend[STAT_BP_LO_BIT +: 3]};
    n.wel   = 1'b0;
    n.busy  = 1'b0;
    n.state = ST_IDLE;
    return n;
  endfunction

  // pin protects only when not serving as a quad data line
  assign hw_locked = s_q.srwd && !s_q.wp_sync[1] && !quad_io_i;

  always_comb begin
    s_d          = s_q;
    s_d.wp_sync  = {s_q.wp_sync[0], wp_n_i};
    s_d.rd_valid = 1'b0;
    s_d.reject   = 1'b0;
    s_d.start    = 1'b0;
    // status reads are answered even while busy
    if (cmd_valid_i && cmd_code_i == CMD_READ_STATUS) begin
      s_d.rd_data  = status_byte(s_q);
      s_d.rd_valid = 1'b1;
    end
    // other commands are dropped silently while busy
    case (s_q.state)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          case (cmd_code_i)
            CMD_WRITE_ENABLE: begin
              s_d.wel = 1'b1;
            end
            CMD_WRITE_DISABLE: begin
              s_d.wel = 1'b0;
            end
            CMD_WRITE_STATUS: begin
              if (status_write_refused(s_q, hw_locked)) begin
                s_d.reject = 1'b1;
                s_d.wel    = 1'b0;
              end else begin
                s_d.pend  = cmd_data_i;
                s_d.cnt   = 16'(WRSR_CYC);
                s_d.busy  = 1'b1;
                s_d.state = ST_STATUS_WRITE;
              end
            end
            CMD_PROGRAM, CMD_ERASE_SECTOR, CMD_ERASE_DIE: begin
              if (array_refused(cmd_code_i, s_q, prot.hit)) begin
                s_d.reject = 1'b1;
                s_d.wel    = 1'b0;
              end else begin
                s_d.start = 1'b1;
                s_d.addr  = cmd_addr_i;
                s_d.busy  = 1'b1;
                s_d.state = ST_ARRAY_OP;
                s_d.op    = array_op_of(cmd_code_i);
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_STATUS_WRITE: begin
        if (s_q.cnt == 16'h0001) begin
          s_d = commit_status(s_d);
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      ST_ARRAY_OP: begin
        if (array_done_i) begin
          s_d.wel   = 1'b0;
          s_d.busy  = 1'b0;
          s_d.state = ST_IDLE;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
        s_d.busy  = 1'b0;
      end
    endcase
    s_d.ready = !s_d.busy;
  end

  // nonvolatile bits come up clear, like a blank part at power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.state <= ST_IDLE;
      s_q.srwd  <= RST_SRWD;
      s_q.tb    <= RST_TB;
      s_q.bp    <= RST_BP;
      s_q.wel   <= RST_WEL;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign status_o      = status_byte(s_q);
  assign flag_ready_o  = s_q.ready;
  assign rd_data_o     = s_q.rd_data;
  assign rd_valid_o    = s_q.rd_valid;
  assign reject_o      = s_q.reject;
  assign array_start_o = s_q.start;
  assign array_op_o    = s_q.op;
  assign array_addr_o  = s_q.addr;
endmodule
`default_nettype wire

/* File: fscwp_array_model.sv */
// array side model answering each started operation with a done pulse
`timescale 1ns/1ps
`default_nettype none
module fscwp_array_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [3:0] lat_i,
  output logic            done_o
);
  logic [4:0] cnt_q;
  initial begin
    cnt_q = 5'h0;
    done_o = 1'b0;
  end
  // lat_i of zero answers two cycles after start, each larger value adds one more cycle
  always @(posedge clk_i) begin
    done_o <= cnt_q == 5'h1;
    if (start_i) cnt_q <= {1'b0, lat_i} + 5'h1;
    else if (cnt_q != 5'h0) cnt_q <= cnt_q - 5'h1;
  end
endmodule
`default_nettype wire

/* File: fscwp_monitor.sv */
// port assertions of the status and protect block
`timescale 1ns/1ps
`default_nettype none
module fscwp_monitor (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        cmd_valid_i,
  input wire fscwp_pkg::fscwp_cmd_type    cmd_code_i,
  input wire logic                        wp_n_i,
  input wire logic                        quad_io_i,
  input wire logic [7:0]                  status_o,
  input wire logic                        flag_ready_o,
  input wire logic                        rd_valid_o,
  input wire logic                        reject_o,
  input wire logic                        array_start_o,
  input wire fscwp_pkg::fscwp_arr_op_type array_op_o
);
  import fscwp_pkg::*;
  wire ws = cmd_valid_i && cmd_code_i == CMD_WRITE_STATUS && !status_o[0];
  wire rd = cmd_valid_i && cmd_code_i == CMD_READ_STATUS;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ready_inverse: assert property (flag_ready_o != status_o[0])
    else $error("ready flag mismatch");
  a_read_answer: assert property (rd |=> rd_valid_o)
    else $error("no read answer");
  a_no_wel_reject: assert property (ws && !status_o[1] |=> reject_o && !status_o[0])
    else $error("write without latch taken");
  a_locked_reject: assert property ((!wp_n_i && !quad_io_i)[*4] ##0 ws && status_o[7] |=> reject_o)
    else $error("locked status written");
  a_start_busy: assert property (array_start_o |-> status_o[0] && !$past(status_o[0]))
    else $error("start without busy");
  a_die_guard: assert property (array_start_o && array_op_o == ARR_ERASE_DIE |->
    {status_o[6], status_o[4:2]} == 4'h0) else $error("die erase while protected");
  a_done_clears_wel: assert property ($fell(status_o[0]) |-> !status_o[1])
    else $error("latch kept after operation");
  a_reset_clean: assert property (disable iff (1'b0) rst_i |=> status_o == 8'h00)
    else $error("status not clear after reset");
  cover property (reject_o);
  cover property (array_start_o);
  cover property (rd_valid_o);
endmodule
bind fscwp_status_protect fscwp_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .wp_n_i(wp_n_i), .quad_io_i(quad_io_i),
  .status_o(status_o), .flag_ready_o(flag_ready_o), .rd_valid_o(rd_valid_o),
  .reject_o(reject_o), .array_start_o(array_start_o), .array_op_o(array_op_o));
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the status and protect block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fscwp_pkg::*;
  logic          clk_i, rst_i, cmd_valid_i, wp_n_i, quad_io_i, array_done_i, start;
  logic          flag_ready_o, rd_valid_o, reject_o;
  logic [3:0]    lat;
  logic [7:0]    cmd_data_i, status_o, rd_data_o;
  logic [31:0]   cmd_addr_i, arr_addr;
  fscwp_cmd_type cmd_code_i;
  fscwp_arr_op_type arr_op;
  int            m_st, miscompares, check_count, cyc;
  wire [4:0] flags = {flag_ready_o, start, status_o[0], reject_o, rd_valid_o};
  fscwp_status_protect #(.WRSR_CYC(4)) i_fscwp_status_protect (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .wp_n_i(wp_n_i), .quad_io_i(quad_io_i), .array_done_i(array_done_i),
    .status_o(status_o), .flag_ready_o(flag_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .reject_o(reject_o), .array_start_o(start), .array_op_o(arr_op),
    .array_addr_o(arr_addr));
  fscwp_array_model i_fscwp_array_model (.clk_i(clk_i), .start_i(start), .lat_i(lat),
    .done_o(array_done_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic bit prot(int bp, int bot, int s);
    int n;
    n = bp >= 13 ? 4096 : (bp == 0 ? 0 : 1 << (bp - 1));
    return bot != 0 ? s < n : s >= 4096 - n;
  endfunction
  task automatic op(input fscwp_cmd_type c, input logic [31:0] a, input logic [7:0] d);
    int bp;
    bit rej, mod, arr;
    bp = {m_st[6], m_st[4:2]};
    rej = 1'b0;
    case (c)
      CMD_WRITE_ENABLE: m_st[1] = 1'b1;
      CMD_WRITE_DISABLE: m_st[1] = 1'b0;
      CMD_READ_STATUS: rej = 1'b0;
      CMD_WRITE_STATUS: rej = !m_st[1] || (m_st[7] && !wp_n_i && !quad_io_i);
      CMD_ERASE_DIE: rej = !m_st[1] || bp != 0;
      default: rej = !m_st[1] || prot(bp, m_st[5], a[27:16]);
    endcase
    mod = !rej && c >= CMD_WRITE_STATUS;
    arr = mod && c != CMD_WRITE_STATUS;
    @(negedge clk_i);
    cmd_code_i = c;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    cmp(flags, {!mod, arr, mod, rej, c == CMD_READ_STATUS});
    if (c == CMD_READ_STATUS) cmp(rd_data_o, m_st[7:0]);
    if (arr) cmp(arr_addr, a);
    if (arr) cmp(32'(arr_op), c == CMD_PROGRAM ? 0 : (c == CMD_ERASE_SECTOR ? 1 : 2));
    if (c == CMD_WRITE_STATUS && !rej) m_st = d & 8'hfc;
    if (rej || arr) m_st[1] = 1'b0;
    while (status_o[0] === 1'b1) @(negedge clk_i);
    cmp(status_o, m_st[7:0]);
  endtask
  task automatic wop(input fscwp_cmd_type c, input logic [31:0] a, input logic [7:0] d);
    op(CMD_WRITE_ENABLE, '0, '0);
    op(c, a, d);
  endtask
  task automatic do_reset;
    rst_i = 1'b1;
    m_st = 0;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  initial begin
    void'($urandom(83944));
    {cmd_valid_i, cmd_addr_i, cmd_data_i, quad_io_i, lat} = '0;
    cmd_code_i = CMD_WRITE_ENABLE;
    wp_n_i = 1'b1;
    do_reset();
    op(CMD_READ_STATUS, '0, '0);
    op(CMD_WRITE_STATUS, '0, 8'h1c);
    for (int i = 0; i < 9; i++) begin
      lat = 4'($urandom_range(9));
      wop(CMD_WRITE_STATUS, '0, 8'($urandom) & 8'h7c);
      wop(fscwp_cmd_type'(4 + i % 3), $urandom, '0);
      op(CMD_READ_STATUS, '0, '0);
    end
    op(CMD_WRITE_ENABLE, '0, '0);
    wop(CMD_WRITE_DISABLE, '0, '0);
    op(CMD_PROGRAM, '0, '0);
    wop(CMD_WRITE_STATUS, '0, 8'h80);
    wp_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    wop(CMD_WRITE_STATUS, '0, 8'h9c);
    quad_io_i = 1'b1;
    wop(CMD_WRITE_STATUS, '0, 8'h84);
    quad_io_i = 1'b0;
    wp_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    wop(CMD_WRITE_STATUS, '0, 8'h00);
    wop(CMD_ERASE_DIE, '0, '0);
    do_reset();
    op(CMD_READ_STATUS, '0, '0);
    report_and_stop();
  end
endmodule
`default_nettype wire
